// ==== itp_core_model.sv ====
// behavioural cpu core that retires instructions and takes requests
`timescale 1ns/1ns
module itp_core_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic exc_req,
    output logic instr_done,
    output logic exc_ack
);
    logic [3:0] wait_q;
    // ****************************************************
    // retire every other cycle while running
    // ****************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= run & ~instr_done;
        end
    end
    // ****************************************************
    // take a standing request after ack_wait cycles
    // ****************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            exc_ack <= 1'b0;
            wait_q <= 4'h0;
        end else if (ack_en && exc_req && !exc_ack) begin
            exc_ack <= (wait_q == ack_wait);
            wait_q <= (wait_q == ack_wait) ? 4'h0 : wait_q + 4'h1;
        end else begin
            exc_ack <= 1'b0;
            wait_q <= 4'h0;
        end
    end
endmodule

// ==== itp_pkg.sv ====
// constants shared by the interrupt and trap prioritizer
package itp_pkg;

    // ********************************************************
    // sizes
    // ********************************************************
    localparam int NUM_SRC = 75;
    localparam int SRC_W = 7;
    localparam int LVL_W = 3;
    localparam int CPL_W = 4;
    localparam int NUM_TRAP = 5;
    localparam int PRIO_WORDS = 10;
    localparam int PRIO_PER_WORD = 8;
    localparam int FLAG_WORDS = 3;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 5;
    localparam int TBLK_W = 14;

    // ********************************************************
    // register byte offsets
    // ********************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CPU = 8'h04;
    localparam logic [7:0] OFS_TBLK = 8'h08;
    localparam logic [7:0] OFS_VEC = 8'h0c;
    localparam logic [7:0] OFS_FLAG0 = 8'h10;
    localparam logic [7:0] OFS_EN0 = 8'h20;
    localparam logic [7:0] OFS_PRIO0 = 8'h40;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int NEST_DIS_BIT = 15;
    localparam int TRAP_FLAG_LSB = 1;
    localparam int CPU_TBLK_BIT = 4;
    localparam int VEC_TRAP_BIT = 11;
    localparam int VEC_REQ_BIT = 12;

    // ********************************************************
    // levels, vectors and reset values
    // ********************************************************
    localparam logic [LVL_W-1:0] LVL_NONE = 3'h0;
    localparam logic [LVL_W-1:0] LVL_MAX = 3'h7;
    localparam logic [LVL_W-1:0] TBLK_LVL = 3'h6;
    localparam logic [CPL_W-1:0] CPL_RST = 4'h0;
    localparam logic [CPL_W-1:0] CPL_NEST_OFF = 4'h7;
    localparam logic [CPL_W-1:0] TRAP_TOP_LVL = 4'hd;
    localparam logic [SRC_W-1:0] TRAP_VEC_BASE = 7'h01;
    localparam logic [TBLK_W-1:0] TBLK_RST = 14'h0000;

endpackage

// ==== itp_prio_if.sv ====
// bundle between the control logic and the priority store
`timescale 1ns/1ns
interface itp_prio_if;
    import itp_pkg::*;
    logic wr_en;
    logic [3:0] wr_word;
    logic [31:0] wr_data;
    logic [3:0] rd_word;
    logic [31:0] rd_data;
    logic [NUM_SRC-1:0] req;
    logic win_valid;
    logic [SRC_W-1:0] win_src;
    logic [LVL_W-1:0] win_lvl;

    modport ctl (
        output wr_en, wr_word, wr_data, rd_word, req,
        input rd_data, win_valid, win_src, win_lvl
    );
    modport store (
        input wr_en, wr_word, wr_data, rd_word, req,
        output rd_data, win_valid, win_src, win_lvl
    );
endinterface

// ==== itp_prio_store.sv ====
// per-source priority store with registered readback and winner
`timescale 1ns/1ns
module itp_prio_store
    import itp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    itp_prio_if.store p
);

    // ********************************************************
    // priority registers
    // ********************************************************
    logic [LVL_W-1:0] prio_q [NUM_SRC];
    logic [31:0] rd_data_q;
    logic win_valid_q;
    logic [SRC_W-1:0] win_src_q;
    logic [LVL_W-1:0] win_lvl_q;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            localparam logic [3:0] WORD = 4'(g / PRIO_PER_WORD);
            localparam int NIB = (g % PRIO_PER_WORD) * 4;
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    prio_q[g] <= LVL_NONE;
                end else if (p.wr_en && p.wr_word == WORD) begin
                    prio_q[g] <= p.wr_data[NIB +: LVL_W];
                end
            end
        end
    endgenerate

    // ********************************************************
    // readback
    // ********************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_data_q <= 32'h0;
        end else begin
            rd_data_q <= 32'h0;
            for (int k = 0; k < PRIO_PER_WORD; k++) begin
                if (int'(p.rd_word) * PRIO_PER_WORD + k < NUM_SRC) begin
                    rd_data_q[k*4 +: LVL_W] <=
                        prio_q[int'(p.rd_word) * PRIO_PER_WORD + k];
                end
            end
        end
    end

    // ********************************************************
    // winner: highest level, then lowest source number
    // ********************************************************
    logic [LVL_W-1:0] best_lvl;
    logic [SRC_W-1:0] best_src;
    always_comb begin
        best_lvl = LVL_NONE;
        best_src = 7'h00;
        for (int i = 0; i < NUM_SRC; i++) begin
            // strict compare keeps the lower number on a tie
            if (p.req[i] && prio_q[i] > best_lvl) begin
                best_lvl = prio_q[i];
                best_src = SRC_W'(i);
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            win_valid_q <= 1'b0;
            win_src_q <= 7'h00;
            win_lvl_q <= LVL_NONE;
        end else begin
            win_valid_q <= best_lvl != LVL_NONE;
            win_src_q <= best_src;
            win_lvl_q <= best_lvl;
        end
    end

    assign p.rd_data = rd_data_q;
    assign p.win_valid = win_valid_q;
    assign p.win_src = win_src_q;
    assign p.win_lvl = win_lvl_q;

endmodule

// ==== itp_top.sv ====
// interrupt and trap prioritizer with avalon-mm register slave
//
// What this block does
// - each source holds a three-bit level, 0 to 7, 7 highest
// - a source at level zero is never forwarded
// - natural rank equals source number, 0 best, 74 worst
// - equal levels resolve to the lowest source number
// - nesting on by default: only a strictly higher level preempts
// - bit 15 of interrupt_control_one turns nesting off
// - with nesting off, taking an interrupt sets the cpu level to 7
// - with nesting off, levels only choose among pending requests
// - with nesting off, software cannot write the cpu level
// - traps are unmaskable, nest, and follow a fixed order
// - five traps: oscillator, address, stack, math, dma error
// - lower trap vector wins; oscillator failure is the highest
// - a trap is presented only after its instruction completes
// - a flag set by software on an enabled source raises a request
// - every source has its own vector, enable and flag
// - timed block holds off levels 6 and below, status bit set
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
module itp_top
    import itp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NUM_SRC-1:0] src_event,
    input wire logic [NUM_TRAP-1:0] trap_event,
    input wire logic instr_done,
    input wire logic exc_ack,
    input wire logic return_from_interrupt,
    output logic exc_req,
    output logic exc_is_trap,
    output logic [SRC_W-1:0] exc_vector,
    output logic [CPL_W-1:0] exc_level,
    output logic [CPL_W-1:0] cpu_priority_level,
    output logic timed_block_active
);

    // ********************************************************
    // decode helpers
    // ********************************************************
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction

    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] base,
                                      input int words);
        return a[7:2] >= base[7:2] &&
               int'(a[7:2]) < int'(base[7:2]) + words;
    endfunction

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_FETCH,
        BUS_DONE
    } itp_bus_type;

    // ********************************************************
    // state
    // ********************************************************
    itp_bus_type bus_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic nest_dis_q;
    logic [NUM_SRC-1:0] flag_q;
    logic [NUM_SRC-1:0] en_q;
    logic [NUM_TRAP-1:0] trap_pend_q;
    logic trap_armed_q;
    logic [CPL_W-1:0] cpl_q;
    logic [CPL_W-1:0] stk_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [TBLK_W-1:0] tblk_q;
    logic tblk_act_q;
    logic req_q;
    logic is_trap_q;
    logic [SRC_W-1:0] vec_q;
    logic [CPL_W-1:0] lvl_q;
    logic hold_q;

    itp_prio_if pif ();

    itp_prio_store u_store (
        .mclk (mclk),
        .reset (reset),
        .p (pif.store)
    );

    // ********************************************************
    // bus slave
    // ********************************************************
    // a write lands on the edge where waitrequest is seen low
    logic wr_fire;
    logic [3:0] word_idx;
    assign wr_fire = avs_write && bus_q == BUS_DONE;
    assign word_idx = avs_address[5:2];

    assign pif.rd_word = word_idx;
    assign pif.wr_word = word_idx;
    assign pif.wr_data = avs_writedata;
    assign pif.wr_en = wr_fire && in_range(avs_address, OFS_PRIO0,
                                           PRIO_WORDS);

    logic [95:0] flag_pad;
    logic [95:0] en_pad;
    assign flag_pad = {{(96-NUM_SRC){1'b0}}, flag_q};
    assign en_pad = {{(96-NUM_SRC){1'b0}}, en_q};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit(avs_address, OFS_CTRL)) begin
            rd_mux[NEST_DIS_BIT] = nest_dis_q;
            rd_mux[TRAP_FLAG_LSB +: NUM_TRAP] = trap_pend_q;
        end else if (hit(avs_address, OFS_CPU)) begin
            rd_mux[CPL_W-1:0] = cpl_q;
            rd_mux[CPU_TBLK_BIT] = tblk_act_q;
        end else if (hit(avs_address, OFS_TBLK)) begin
            rd_mux[TBLK_W-1:0] = tblk_q;
        end else if (hit(avs_address, OFS_VEC)) begin
            rd_mux[SRC_W-1:0] = vec_q;
            rd_mux[SRC_W +: CPL_W] = lvl_q;
            rd_mux[VEC_TRAP_BIT] = is_trap_q;
            rd_mux[VEC_REQ_BIT] = req_q;
        end else if (in_range(avs_address, OFS_FLAG0, FLAG_WORDS)) begin
            rd_mux = flag_pad[32*int'(word_idx[1:0]) +: 32];
        end else if (in_range(avs_address, OFS_EN0, FLAG_WORDS)) begin
            rd_mux = en_pad[32*int'(word_idx[1:0]) +: 32];
        end else if (in_range(avs_address, OFS_PRIO0, PRIO_WORDS)) begin
            rd_mux = pif.rd_data;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_q <= BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_q <= BUS_FETCH;
                    end
                end
                BUS_FETCH: begin
                    bus_q <= BUS_DONE;
                    wait_q <= 1'b0;
                    rdata_q <= avs_read ? rd_mux : 32'h0;
                end
                BUS_DONE: begin
                    bus_q <= BUS_IDLE;
                    wait_q <= 1'b1;
                end
                default: begin
                    bus_q <= BUS_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    // ********************************************************
    // control bit
    // ********************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            nest_dis_q <= 1'b0;
        end else if (wr_fire && hit(avs_address, OFS_CTRL)) begin
            nest_dis_q <= avs_writedata[NEST_DIS_BIT];
        end
    end

    // ********************************************************
    // flags and enables
    // ********************************************************
    logic [95:0] flag_wr;
    logic [NUM_SRC-1:0] flag_d;
    always_comb begin
        flag_wr = flag_pad;
        if (wr_fire && in_range(avs_address, OFS_FLAG0, FLAG_WORDS)) begin
            flag_wr[32*int'(word_idx[1:0]) +: 32] = avs_writedata;
        end
        // a peripheral event wins over a clearing write
        flag_d = flag_wr[NUM_SRC-1:0] | src_event;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            en_q <= '0;
        end else if (wr_fire &&
                     in_range(avs_address, OFS_EN0, FLAG_WORDS)) begin
            for (int b = 0; b < 32; b++) begin
                if (32*int'(word_idx[1:0]) + b < NUM_SRC) begin
                    en_q[32*int'(word_idx[1:0]) + b] <= avs_writedata[b];
                end
            end
        end
    end

    // software flags count like peripheral ones
    assign pif.req = flag_q & en_q;

    // ********************************************************
    // traps
    // ********************************************************
    logic trap_any;
    logic [SRC_W-1:0] trap_vec;
    logic [CPL_W-1:0] trap_lvl;
    always_comb begin
        trap_any = 1'b0;
        trap_vec = TRAP_VEC_BASE;
        trap_lvl = TRAP_TOP_LVL;
        for (int t = NUM_TRAP - 1; t >= 0; t--) begin
            if (trap_pend_q[t]) begin
                trap_any = 1'b1;
                trap_vec = TRAP_VEC_BASE + SRC_W'(t);
                trap_lvl = TRAP_TOP_LVL - CPL_W'(t);
            end
        end
    end

    logic take;
    assign take = exc_ack && req_q;

    logic [NUM_TRAP-1:0] trap_clr;
    always_comb begin
        trap_clr = '0;
        if (take && is_trap_q) begin
            trap_clr[3'(vec_q - TRAP_VEC_BASE)] = 1'b1;
        end
        if (wr_fire && hit(avs_address, OFS_CTRL)) begin
            trap_clr = trap_clr |
                       avs_writedata[TRAP_FLAG_LSB +: NUM_TRAP];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            trap_pend_q <= '0;
        end else begin
            trap_pend_q <= (trap_pend_q & ~trap_clr) | trap_event;
        end
    end

    // hold off until the faulting instruction has retired
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            trap_armed_q <= 1'b0;
        end else if (instr_done && (trap_any || |trap_event)) begin
            trap_armed_q <= 1'b1;
        end else if (!trap_any) begin
            trap_armed_q <= 1'b0;
        end
    end

    // ********************************************************
    // timed block
    // ********************************************************
    logic [TBLK_W-1:0] tblk_d;
    always_comb begin
        tblk_d = tblk_q;
        if (wr_fire && hit(avs_address, OFS_TBLK)) begin
            tblk_d = avs_writedata[TBLK_W-1:0];
        end else if (tblk_q != TBLK_RST) begin
            tblk_d = tblk_q - 14'h0001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tblk_q <= TBLK_RST;
            tblk_act_q <= 1'b0;
        end else begin
            tblk_q <= tblk_d;
            tblk_act_q <= tblk_d != TBLK_RST;
        end
    end

    // ********************************************************
    // presentation to the core
    // ********************************************************
    logic pres;
    logic pres_trap;
    logic [SRC_W-1:0] pres_vec;
    logic [CPL_W-1:0] pres_lvl;
    logic irq_ok;
    assign irq_ok = pif.win_valid &&
                    {1'b0, pif.win_lvl} > cpl_q &&
                    !(tblk_act_q && pif.win_lvl <= TBLK_LVL);

    always_comb begin
        pres = 1'b0;
        pres_trap = 1'b0;
        pres_vec = 7'h00;
        pres_lvl = CPL_RST;
        if (trap_armed_q && trap_any && trap_lvl > cpl_q) begin
            pres = 1'b1;
            pres_trap = 1'b1;
            pres_vec = trap_vec;
            pres_lvl = trap_lvl;
        end else if (irq_ok) begin
            pres = 1'b1;
            pres_vec = pif.win_src;
            pres_lvl = {1'b0, pif.win_lvl};
        end
    end

    // two idle cycles after a take let the new level settle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            req_q <= 1'b0;
            is_trap_q <= 1'b0;
            vec_q <= 7'h00;
            lvl_q <= CPL_RST;
            hold_q <= 1'b0;
        end else begin
            hold_q <= take;
            req_q <= pres && !take && !hold_q;
            if (!req_q || !take) begin
                is_trap_q <= pres_trap;
                vec_q <= pres_vec;
                lvl_q <= pres_lvl;
            end
        end
    end

    // ********************************************************
    // cpu priority level and nesting stack
    // ********************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cpl_q <= CPL_RST;
            sp_q <= '0;
        end else if (take) begin
            if (sp_q != SP_W'(STACK_DEPTH)) begin
                sp_q <= sp_q + 5'h01;
            end
            if (!is_trap_q && nest_dis_q) begin
                cpl_q <= CPL_NEST_OFF;
            end else begin
                cpl_q <= lvl_q;
            end
        end else if (return_from_interrupt && sp_q != '0) begin
            sp_q <= sp_q - 5'h01;
            cpl_q <= stk_q[4'(sp_q - 5'h01)];
        end else if (wr_fire && hit(avs_address, OFS_CPU) &&
                     !nest_dis_q && !cpl_q[CPL_W-1]) begin
            cpl_q <= {1'b0, avs_writedata[LVL_W-1:0]};
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int s = 0; s < STACK_DEPTH; s++) begin
                stk_q[s] <= CPL_RST;
            end
        end else if (take && sp_q != SP_W'(STACK_DEPTH)) begin
            stk_q[4'(sp_q)] <= cpl_q;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign exc_req = req_q;
    assign exc_is_trap = is_trap_q;
    assign exc_vector = vec_q;
    assign exc_level = lvl_q;
    assign cpu_priority_level = cpl_q;
    assign timed_block_active = tblk_act_q;

endmodule

// ==== itp_top_assertions.sv ====
// port assertions for the interrupt and trap prioritizer
`timescale 1ns/1ns
module itp_top_checker
    import itp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic exc_ack,
    input wire logic exc_req,
    input wire logic exc_is_trap,
    input wire logic [SRC_W-1:0] exc_vector,
    input wire logic [CPL_W-1:0] exc_level,
    input wire logic [CPL_W-1:0] cpu_priority_level,
    input wire logic timed_block_active
);
    // ****************************************************
    // properties
    // ****************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_take_gap: assert property (
        exc_req && exc_ack |=> !exc_req [*2])
        else $error("req kept after take");
    a_take_level: assert property (
        exc_req && exc_ack |=> cpu_priority_level == $past(exc_level)
        || (!$past(exc_is_trap) && cpu_priority_level == 4'h7))
        else $error("cpu level wrong after take");
    a_above_cpu: assert property (
        exc_req && !exc_is_trap
        && cpu_priority_level == $past(cpu_priority_level, 4)
        |-> exc_level > cpu_priority_level)
        else $error("request not above cpu level");
    a_zero_level: assert property (
        exc_req |-> exc_level != 4'h0)
        else $error("level zero request presented");
    a_vec_range: assert property (
        exc_req && !exc_is_trap
        |-> exc_vector < 7'd75 && exc_level inside {[4'h1:4'h7]})
        else $error("bad vector or level");
    a_trap_order: assert property (
        exc_req && exc_is_trap |-> exc_vector inside {[7'h01:7'h05]}
        && exc_level == 4'he - exc_vector[3:0])
        else $error("bad trap level");
    a_block_mask: assert property (
        exc_req && !exc_is_trap && timed_block_active
        && $past(timed_block_active, 4) |-> exc_level == 4'h7)
        else $error("blocked level presented");
    a_block_start: assert property (
        avs_write && avs_address == OFS_TBLK && !avs_waitrequest
        && avs_writedata[13:0] != 14'h0 |=> timed_block_active)
        else $error("block not started");
    a_bus_answer: assert property (
        $rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest
        ##1 !avs_waitrequest)
        else $error("late read answer");
endmodule

bind itp_top itp_top_checker i_chk (.*);

// ==== testbench.sv ====
// register-level testbench for the interrupt and trap prioritizer
`timescale 1ns/1ns
module testbench;
    import itp_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, instr_done, exc_ack, exc_req, exc_is_trap;
    logic [NUM_SRC-1:0] src_event = '0;
    logic [NUM_TRAP-1:0] trap_event = '0;
    logic return_from_interrupt = 1'b0;
    logic run = 1'b1;
    logic ack_en = 1'b0;
    logic [3:0] ack_wait = 4'h0;
    logic [SRC_W-1:0] exc_vector;
    logic [CPL_W-1:0] exc_level, cpu_priority_level;
    logic timed_block_active;
    int num_errors = 0;
    int total_checks = 0;
    int n;

    always #5 mclk = ~mclk;

    itp_top i_itp_top (.*);
    itp_core_model i_itp_core_model (.*);

    // ****************************************************
    // tasks
    // ****************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            end_of_test();
        end
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic ev(input logic [74:0] s, input logic [4:0] t);
        @(posedge mclk);
        src_event <= s;
        trap_event <= t;
        @(posedge mclk);
        src_event <= '0;
        trap_event <= '0;
    endtask
    task automatic want(input logic t, input logic [6:0] v,
                        input logic [3:0] l);
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (exc_req !== 1'b1 && k < 12);
        chk({exc_req, exc_is_trap, exc_vector, exc_level}, {1'b1, t, v, l});
    endtask
    task automatic quiet;
        repeat (6) begin
            @(posedge mclk);
            chk(exc_req, 1'b0);
        end
    endtask
    task automatic take(input logic [3:0] w, input logic [3:0] l);
        int k;
        ack_wait <= w;
        ack_en <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (exc_ack !== 1'b1 && k < 20);
        ack_en <= 1'b0;
        @(posedge mclk);
        chk(cpu_priority_level, l);
    endtask
    task automatic ret;
        @(posedge mclk);
        return_from_interrupt <= 1'b1;
        @(posedge mclk);
        return_from_interrupt <= 1'b0;
    endtask

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_VEC, 32'h0);
        wr(8'h80, 32'hffff);
        rd(8'h80, 32'h0);
        wr(OFS_PRIO0, 32'h4000);
        wr(OFS_PRIO0 + 8'h04, 32'h0400);
        wr(OFS_EN0, 32'h0428);
        wr(OFS_FLAG0, 32'h0028);
        ev(75'h400, 5'h0);
        want(1'b0, 7'd3, 4'h4);
        take(4'h0, 4'h4);
        quiet();
        wr(OFS_PRIO0 + 8'h24, 32'hfff7ff);
        rd(OFS_PRIO0 + 8'h24, 32'h0777);
        wr(OFS_EN0 + 8'h08, 32'h0400);
        wr(OFS_FLAG0 + 8'h08, 32'h0400);
        want(1'b0, 7'd74, 4'h7);
        take(4'h3, 4'h7);
        wr(OFS_FLAG0, 32'h0020);
        wr(OFS_FLAG0 + 8'h08, 32'h0);
        ret();
        ret();
        quiet();
        wr(OFS_CTRL, 32'h8000);
        rd(OFS_CTRL, 32'h8000);
        wr(OFS_FLAG0, 32'h0400);
        want(1'b0, 7'd10, 4'h4);
        take(4'h1, 4'h7);
        wr(OFS_CPU, 32'h0);
        rd(OFS_CPU, 32'h7);
        wr(OFS_FLAG0 + 8'h08, 32'h0400);
        quiet();
        wr(OFS_FLAG0, 32'h0);
        wr(OFS_FLAG0 + 8'h08, 32'h0);
        wr(OFS_CTRL, 32'h0);
        ret();
        rd(OFS_CPU, 32'h0);
        wr(OFS_TBLK, 32'd200);
        rd(OFS_CPU, 32'h10);
        wr(OFS_FLAG0, 32'h0400);
        quiet();
        wr(OFS_FLAG0 + 8'h08, 32'h0400);
        want(1'b0, 7'd74, 4'h7);
        wr(OFS_FLAG0, 32'h0);
        wr(OFS_FLAG0 + 8'h08, 32'h0);
        n = 0;
        while (timed_block_active !== 1'b0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk(timed_block_active, 1'b0);
        for (int k = 0; k < 5; k++) begin
            run <= 1'b0;
            ev(75'h0, 5'h1 << k);
            quiet();
            rd(OFS_CTRL, 32'h2 << k);
            run <= 1'b1;
            want(1'b1, 7'(k + 1), 4'(13 - k));
            take(4'h0, 4'(13 - k));
            ret();
        end
        ev(75'h0, 5'h10);
        want(1'b1, 7'd5, 4'h9);
        take(4'h2, 4'h9);
        ev(75'h0, 5'h01);
        want(1'b1, 7'd1, 4'hd);
        take(4'h0, 4'hd);
        ret();
        ret();
        rd(OFS_CPU, 32'h0);
        end_of_test();
    end
endmodule
